// ### sync_serial_port_regs.sv
// two synchronous serial ports behind one classic Wishbone slave
// assumes a single-cycle classic master that waits for ack; one clock domain
//
// The implementer's own choice: the Wishbone interface to the registers.
module sync_serial_port_regs
	import serial_port_pkg::*;
(
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// wishbone slave
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [31:0]   wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic [31:0]        wb_dat_o,
	output logic               wb_ack_o,
	// serial lines, one entry per port
	input  wire logic [NUM_PORTS-1:0] miso_i,
	output serial_out_t [NUM_PORTS-1:0] pins_o,
	// interrupt
	output logic               irq_o
);

	localparam logic [NUM_PORTS-1:0][31:0] PORT_BASE = {PORT_BASE_1, PORT_BASE_0};

	logic                       ack_q;
	logic [31:0]                rdata_q;
	logic                       req;
	logic                       req_new;
	logic                       wr_acc;
	logic                       rd_acc;
	logic [11:0]                ofs;
	logic                       aligned;
	logic [NUM_PORTS-1:0]       port_hit;
	logic [NUM_PORTS-1:0][31:0] rd_word;
	logic [NUM_PORTS-1:0]       port_irq;
	logic [31:0]                lane_mask;
	logic [31:0]                rdata_sel;

	// bus phases: a new request is answered one edge later; the write or the
	// queue pop happens on the edge where the master sees ack high
	assign req       = wb_cyc_i & wb_stb_i;
	assign req_new   = req & ~ack_q;
	assign wr_acc    = req & ack_q & wb_we_i;
	assign rd_acc    = req & ack_q & ~wb_we_i;
	assign ofs       = wb_adr_i[PAGE_LSB-1:0];
	assign aligned   = (wb_adr_i[1:0] == 2'h0);
	assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wb_ack_o  = ack_q;
	assign wb_dat_o  = rdata_q;
	assign irq_o     = |port_irq;

	// each port claims its own 4 KiB page; unmapped addresses read zero
	generate
		for (genvar h = 0; h < NUM_PORTS; h++) begin : g_hit
			assign port_hit[h] = aligned
			                   & (wb_adr_i[31:PAGE_LSB] == PORT_BASE[h][31:PAGE_LSB]);
		end
	endgenerate

	// read data is captured with ack so that a queue pop cannot change it
	always_comb begin
		rdata_sel = 32'h0000_0000;
		for (int s = 0; s < NUM_PORTS; s++) begin
			if (port_hit[s]) begin
				rdata_sel = rd_word[s];
			end
		end
	end

	// ack is a single cycle; the master must drop stb before the next access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= req_new;
			if (req_new) begin
				rdata_q <= rdata_sel;
			end
		end
	end

	// one identical port per base address
	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
			logic [CTRL0_W-1:0]    ctrl0_q;
			logic [CTRL1_W-1:0]    ctrl1_q;
			logic [PRESCALE_W-1:0] prescale_q;
			logic [IRQ_W-1:0]      mask_q;
			logic [STICKY_W-1:0]   sticky_q;
			logic [STICKY_W-1:0]   sticky_set;
			logic [STICKY_W-1:0]   sticky_clr;
			logic [31:0]           ctrl0_merge;
			logic [31:0]           ctrl1_merge;
			logic [31:0]           prescale_merge;
			logic [31:0]           mask_merge;
			logic                  wr_ctrl0;
			logic                  wr_ctrl1;
			logic                  wr_data;
			logic                  wr_prescale;
			logic                  wr_mask;
			logic                  wr_clear;
			logic                  rd_data;
			logic [WORD_W-1:0]     tx_word;
			logic [FIFO_AW:0]      tx_count;
			logic                  tx_empty;
			logic                  tx_full;
			logic [WORD_W-1:0]     rx_head;
			logic [WORD_W-1:0]     rx_word;
			logic [FIFO_AW:0]      rx_count;
			logic                  rx_empty;
			logic                  rx_full;
			logic                  rx_valid;
			logic                  busy;
			logic                  start;
			logic                  enabled;
			logic                  is_master;
			logic                  sck;
			logic                  mosi;
			logic                  ssel_n;
			logic [STATUS_W-1:0]   status;
			logic [IRQ_W-1:0]      raw;
			logic [IRQ_W-1:0]      masked;
			logic [WORD_W-1:0]     data_read;
			frame_cfg_t            cfg;
			bus_format_t           fmt;

			// write strobes per register; read-only offsets have none
			assign wr_ctrl0    = wr_acc & port_hit[p] & (ofs == OFS_CONTROL_ZERO);
			assign wr_ctrl1    = wr_acc & port_hit[p] & (ofs == OFS_CONTROL_ONE);
			assign wr_data     = wr_acc & port_hit[p] & (ofs == OFS_FIFO_DATA)
			                   & (|wb_sel_i);
			assign wr_prescale = wr_acc & port_hit[p] & (ofs == OFS_CLOCK_PRESCALE);
			assign wr_mask     = wr_acc & port_hit[p] & (ofs == OFS_INTERRUPT_MASK);
			assign wr_clear    = wr_acc & port_hit[p] & (ofs == OFS_INTERRUPT_CLEAR);
			assign rd_data     = rd_acc & port_hit[p] & (ofs == OFS_FIFO_DATA);

			// byte lanes not selected keep their old contents
			assign ctrl0_merge    = (32'(ctrl0_q) & ~lane_mask) | (wb_dat_i & lane_mask);
			assign ctrl1_merge    = (32'(ctrl1_q) & ~lane_mask) | (wb_dat_i & lane_mask);
			assign prescale_merge = (32'(prescale_q) & ~lane_mask) | (wb_dat_i & lane_mask);
			assign mask_merge     = (32'(mask_q) & ~lane_mask) | (wb_dat_i & lane_mask);

			// mode decode; the reserved format code is run like the non-SPI formats, idle and edge bits ignored
			assign fmt       = bus_format_t'(ctrl0_q[FORMAT_LSB +: FORMAT_W]);
			assign enabled   = ctrl1_q[ENABLE_BIT];
			assign is_master = ~ctrl1_q[SLAVE_BIT];
			assign cfg.frame_size_field  = ctrl0_q[SIZE_LSB +: SIZE_W];
			assign cfg.clock_idle_level  = (fmt == FMT_SPI) & ctrl0_q[IDLE_LEVEL_BIT];
			assign cfg.clock_sample_edge = (fmt == FMT_SPI) & ctrl0_q[SAMPLE_EDGE_BIT];
			assign cfg.bit_rate_field    = ctrl0_q[RATE_LSB +: RATE_W];
			assign cfg.prescale_divisor  = prescale_q;
			assign cfg.loopback          = ctrl1_q[LOOPBACK_BIT];

			// a frame starts whenever an enabled master is idle with data queued
			assign start = enabled & is_master & ~busy & ~tx_empty;

			word_fifo #(
				.WIDTH (WORD_W),
				.DEPTH (FIFO_DEPTH),
				.AW    (FIFO_AW)
			) u_tx_fifo (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.push_i  (wr_data),
				.data_i  (wb_dat_i[WORD_W-1:0]),
				.pop_i   (start),
				.data_o  (tx_word),
				.count_o (tx_count),
				.empty_o (tx_empty),
				.full_o  (tx_full)
			);

			serial_shifter u_shifter (
				.clk_i      (clk_i),
				.rst_i      (rst_i),
				.cfg_i      (cfg),
				.start_i    (start),
				.tx_word_i  (tx_word),
				.miso_i     (miso_i[p]),
				.sck_o      (sck),
				.mosi_o     (mosi),
				.ssel_n_o   (ssel_n),
				.busy_o     (busy),
				.rx_valid_o (rx_valid),
				.rx_word_o  (rx_word)
			);

			// a received word that finds the queue full is dropped
			word_fifo #(
				.WIDTH (WORD_W),
				.DEPTH (FIFO_DEPTH),
				.AW    (FIFO_AW)
			) u_rx_fifo (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.push_i  (rx_valid),
				.data_i  (rx_word),
				.pop_i   (rd_data),
				.data_o  (rx_head),
				.count_o (rx_count),
				.empty_o (rx_empty),
				.full_o  (rx_full)
			);

			// sticky events and their clears; a set in the clearing cycle wins
			assign sticky_set[IRQ_OVERRUN] = rx_valid & rx_full;
			assign sticky_set[IRQ_RX_DONE] = rx_valid;
			assign sticky_clr = wr_clear ? wb_dat_i[STICKY_W-1:0] : '0;

			// status and raw interrupt views come only from queue, shifter busy and event state; the masked view also takes mask_q
			assign status[ST_TX_EMPTY]     = tx_empty;
			assign status[ST_TX_NOT_FULL]  = ~tx_full;
			assign status[ST_RX_NOT_EMPTY] = ~rx_empty;
			assign status[ST_RX_FULL]      = rx_full;
			assign status[ST_BUSY]         = busy | ~tx_empty;
			assign raw[STICKY_W-1:0]       = sticky_q;
			assign raw[IRQ_RX_HALF]        = (rx_count >= FIFO_HALF);
			assign raw[IRQ_TX_HALF]        = (tx_count <= FIFO_HALF);
			assign masked      = raw & mask_q;
			assign port_irq[p] = |masked;
			assign data_read   = rx_empty ? '0 : rx_head;

			// read view; reserved bits and the clear register read as zero
			assign rd_word[p] =
				(ofs == OFS_CONTROL_ZERO)     ? 32'(ctrl0_q)    :
				(ofs == OFS_CONTROL_ONE)      ? 32'(ctrl1_q)    :
				(ofs == OFS_FIFO_DATA)        ? 32'(data_read)  :
				(ofs == OFS_PORT_STATUS)      ? 32'(status)     :
				(ofs == OFS_CLOCK_PRESCALE)   ? 32'(prescale_q) :
				(ofs == OFS_INTERRUPT_MASK)   ? 32'(mask_q)     :
				(ofs == OFS_RAW_INTERRUPT)    ? 32'(raw)        :
				(ofs == OFS_MASKED_INTERRUPT) ? 32'(masked)     : 32'h0000_0000;

			// pins are only driven by an enabled master; a slave stays off the bus
			assign pins_o[p].sck      = sck;
			assign pins_o[p].mosi     = mosi;
			assign pins_o[p].ssel_n   = ssel_n;
			assign pins_o[p].drive_en = enabled & is_master;

			// software registers; frame settings changed mid-frame act on the next frame, enable and role bits act at once
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					ctrl0_q    <= CTRL0_RST;
					ctrl1_q    <= CTRL1_RST;
					prescale_q <= PRESCALE_RST;
					mask_q     <= MASK_RST;
				end else begin
					if (wr_ctrl0) begin
						ctrl0_q <= ctrl0_merge[CTRL0_W-1:0];
					end
					if (wr_ctrl1) begin
						ctrl1_q <= ctrl1_merge[CTRL1_W-1:0];
					end
					if (wr_prescale) begin
						prescale_q <= prescale_merge[PRESCALE_W-1:0];
					end
					if (wr_mask) begin
						mask_q <= mask_merge[IRQ_W-1:0];
					end
				end
			end

			// sticky flags: set has priority over a same-cycle clear
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sticky_q <= STICKY_RST;
				end else begin
					sticky_q <= (sticky_q & ~sticky_clr) | sticky_set;
				end
			end
		end
	endgenerate

endmodule : sync_serial_port_regs

// ### serial_port_pkg.sv
// constants, field layouts and carrier types shared by the serial port design
// assumes a single 40 MHz clock and classic Wishbone register access
// Summary of operation
// - two identical ports, register blocks based at 0x4004_0000 and 0x4005_8000.
// - data register write pushes transmit queue; read pops receive queue.
// - frame size field bits 3:0 gives value plus one bits; resets to zero.
// - reset values cover implemented bits; reserved bits read as zero.
// - control_zero holds bit rate, bus format and frame size; read and write.
// - control_one holds role selection and mode options; read and write.
// - interrupt_clear is write only and clears sticky interrupt flags.
// - format field bits 5:4 selects SPI, synchronous serial, three-wire.
// - SPI clock idles at the idle level bit between frames.
// - SPI samples on first transition if edge bit clear, else second.
// - bit rate equals clock over prescale divisor times rate field plus one.
package serial_port_pkg;

	localparam int          NUM_PORTS = 2;
	localparam int          PAGE_LSB  = 12;
	localparam logic [31:0] PORT_BASE_0 = 32'h4004_0000;
	localparam logic [31:0] PORT_BASE_1 = 32'h4005_8000;

	// register offsets inside one port page
	localparam logic [11:0] OFS_CONTROL_ZERO    = 12'h000;
	localparam logic [11:0] OFS_CONTROL_ONE     = 12'h004;
	localparam logic [11:0] OFS_FIFO_DATA       = 12'h008;
	localparam logic [11:0] OFS_PORT_STATUS     = 12'h00C;
	localparam logic [11:0] OFS_CLOCK_PRESCALE  = 12'h010;
	localparam logic [11:0] OFS_INTERRUPT_MASK  = 12'h014;
	localparam logic [11:0] OFS_RAW_INTERRUPT   = 12'h018;
	localparam logic [11:0] OFS_MASKED_INTERRUPT = 12'h01C;
	localparam logic [11:0] OFS_INTERRUPT_CLEAR = 12'h020;

	// implemented widths and reset values
	localparam int          CTRL0_W    = 16;
	localparam int          CTRL1_W    = 3;
	localparam int          PRESCALE_W = 8;
	localparam int          STATUS_W   = 5;
	localparam int          IRQ_W      = 4;
	localparam int          STICKY_W   = 2;
	localparam logic [CTRL0_W-1:0]    CTRL0_RST    = 16'h0000;
	localparam logic [CTRL1_W-1:0]    CTRL1_RST    = 3'h0;
	localparam logic [PRESCALE_W-1:0] PRESCALE_RST = 8'h00;
	localparam logic [IRQ_W-1:0]      MASK_RST     = 4'h0;
	localparam logic [STICKY_W-1:0]   STICKY_RST   = 2'h0;
	localparam logic [PRESCALE_W-1:0] MIN_PRESCALE = 8'h02;

	// control_zero fields
	localparam int SIZE_LSB        = 0;
	localparam int SIZE_W          = 4;
	localparam int FORMAT_LSB      = 4;
	localparam int FORMAT_W        = 2;
	localparam int IDLE_LEVEL_BIT  = 6;
	localparam int SAMPLE_EDGE_BIT = 7;
	localparam int RATE_LSB        = 8;
	localparam int RATE_W          = 8;

	// control_one fields
	localparam int LOOPBACK_BIT = 0;
	localparam int ENABLE_BIT   = 1;
	localparam int SLAVE_BIT    = 2;

	// port_status bits
	localparam int ST_TX_EMPTY     = 0;
	localparam int ST_TX_NOT_FULL  = 1;
	localparam int ST_RX_NOT_EMPTY = 2;
	localparam int ST_RX_FULL      = 3;
	localparam int ST_BUSY         = 4;

	// interrupt bits; the low two are sticky, the high two are levels
	localparam int IRQ_OVERRUN = 0;
	localparam int IRQ_RX_DONE = 1;
	localparam int IRQ_RX_HALF = 2;
	localparam int IRQ_TX_HALF = 3;

	// queues and frame words
	localparam int WORD_W     = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_AW    = 3;
	localparam logic [FIFO_AW:0] FIFO_HALF = 4'h4;
	localparam logic [SIZE_W-1:0] SIZE_MAX = 4'hF;

	typedef enum logic [FORMAT_W-1:0] {FMT_SPI, FMT_SYNC_SERIAL, FMT_THREE_WIRE, FMT_RESERVED} bus_format_t;
	typedef enum logic {SH_IDLE, SH_RUN} shift_state_t;

	// frame settings captured by the shifter when a frame begins
	typedef struct packed {
		logic [SIZE_W-1:0]     frame_size_field;
		logic                  clock_idle_level;
		logic                  clock_sample_edge;
		logic [RATE_W-1:0]     bit_rate_field;
		logic [PRESCALE_W-1:0] prescale_divisor;
		logic                  loopback;
	} frame_cfg_t;

	// serial pins driven by one port
	typedef struct packed {
		logic sck;
		logic mosi;
		logic ssel_n;
		logic drive_en;
	} serial_out_t;

endpackage : serial_port_pkg

// ### word_fifo.sv
// small first-in first-out queue of words
// assumes the user never relies on a push when full or a pop when empty
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	// fill side
	input  wire logic          push_i,
	input  wire logic [WIDTH-1:0] data_i,
	// drain side
	input  wire logic          pop_i,
	output logic [WIDTH-1:0]   data_o,
	// fill level
	output logic [AW:0]        count_o,
	output logic               empty_o,
	output logic               full_o
);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             do_push;
	logic             do_pop;

	// refused operations leave the queue untouched
	assign do_push = push_i & ~full_o;
	assign do_pop  = pop_i & ~empty_o;
	assign empty_o = (cnt_q == '0);
	assign full_o  = (cnt_q == (AW+1)'(DEPTH));
	assign count_o = cnt_q;
	assign data_o  = mem_q[rd_q];

	// storage is not reset; only the pointers and the count carry control state
	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem_q[wr_q] <= data_i;
		end
	end

	// pointers wrap naturally since depth is a power of two
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			wr_q  <= wr_q + AW'(do_push);
			rd_q  <= rd_q + AW'(do_pop);
			cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

endmodule : word_fifo

// ### serial_shifter.sv
// master frame shifter: clock, select and data for one frame at a time
// assumes start is only raised while idle and with a word ready
module serial_shifter
	import serial_port_pkg::*;
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// frame request
	input  wire frame_cfg_t       cfg_i,
	input  wire logic             start_i,
	input  wire logic [WORD_W-1:0] tx_word_i,
	// serial data in
	input  wire logic             miso_i,
	// serial lines out
	output logic                  sck_o,
	output logic                  mosi_o,
	output logic                  ssel_n_o,
	// frame result
	output logic                  busy_o,
	output logic                  rx_valid_o,
	output logic [WORD_W-1:0]     rx_word_o
);

	shift_state_t     state_q;
	frame_cfg_t       cfg_q;
	logic [WORD_W-1:0] tx_q;
	logic [WORD_W-1:0] rx_q;
	logic [WORD_W-1:0] rx_word_q;
	logic             rx_valid_q;
	logic [SIZE_W-1:0] bit_q;
	logic             half_q;
	logic [15:0]      cnt_q;
	logic [PRESCALE_W-1:0] pre_eff;
	logic [16:0]      period;
	logic [15:0]      half_len;
	logic             half_end;
	logic             in_bit;
	logic [WORD_W-1:0] size_mask;

	// divisors below the minimum would give a zero-length half bit
	assign pre_eff   = (cfg_q.prescale_divisor < MIN_PRESCALE) ? MIN_PRESCALE
	                 : cfg_q.prescale_divisor;
	assign period    = 17'(pre_eff) * 17'({1'b0, cfg_q.bit_rate_field} + 9'h001);
	assign half_len  = period[16:1];
	assign half_end  = (cnt_q == half_len - 16'h0001);
	assign in_bit    = cfg_q.loopback ? mosi_o : miso_i;
	assign size_mask = 16'hFFFF >> (SIZE_MAX - cfg_q.frame_size_field);

	// clock idles at the level bit, toggles mid-bit; edge bit shifts by half
	assign sck_o      = (state_q == SH_RUN) ? (cfg_q.clock_idle_level ^ half_q
	                    ^ cfg_q.clock_sample_edge) : cfg_i.clock_idle_level;
	assign mosi_o     = tx_q[bit_q];
	assign ssel_n_o   = (state_q != SH_RUN);
	assign busy_o     = (state_q == SH_RUN);
	assign rx_valid_o = rx_valid_q;
	assign rx_word_o  = rx_word_q;

	// data is sampled at mid-bit, which is the first clock transition when
	// the edge bit is clear and the second when set; msb goes first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q    <= SH_IDLE;
			cfg_q      <= '0;
			tx_q       <= '0;
			rx_q       <= '0;
			rx_word_q  <= '0;
			rx_valid_q <= 1'b0;
			bit_q      <= '0;
			half_q     <= 1'b0;
			cnt_q      <= '0;
		end else begin
			rx_valid_q <= 1'b0;
			case (state_q)
				SH_IDLE: begin
					if (start_i) begin
						state_q <= SH_RUN;
						cfg_q   <= cfg_i;
						tx_q    <= tx_word_i;
						bit_q   <= cfg_i.frame_size_field;
						half_q  <= 1'b0;
						cnt_q   <= '0;
					end
				end
				SH_RUN: begin
					if (!half_end) begin
						cnt_q <= cnt_q + 16'h0001;
					end else begin
						cnt_q <= '0;
						if (!half_q) begin
							half_q <= 1'b1;
							rx_q   <= {rx_q[WORD_W-2:0], in_bit};
						end else begin
							half_q <= 1'b0;
							if (bit_q == '0) begin
								state_q    <= SH_IDLE;
								rx_valid_q <= 1'b1;
								rx_word_q  <= rx_q & size_mask;
							end else begin
								bit_q <= bit_q - 4'h1;
							end
						end
					end
				end
				default: begin
					state_q <= SH_IDLE;
				end
			endcase
		end
	end

endmodule : serial_shifter

// ### echo_slave.sv
// serial slave stand-in for one port: echoes master data while selected
// assumes the port's pin struct; a released line never repeats its last level
module echo_slave
	import serial_port_pkg::*;
(
	// clock
	input  wire logic        clk_i,
	// master side
	input  wire serial_out_t pins_i,
	// reply
	output logic             miso_o
);
	logic last_q = 1'b0;
	// inverse of the last level while unselected, so a stale bit cannot pass
	always_ff @(posedge clk_i) begin
		last_q <= miso_o;
	end
	assign miso_o = pins_i.ssel_n ? ~last_q : pins_i.mosi;
endmodule : echo_slave

// ### sync_serial_port_regs_checker.sv
// port-level checks of the serial register block, port 0 pins
// assumes one clock domain and a synchronous active-high reset
module sync_serial_port_regs_checker
	import serial_port_pkg::*;
(
	// clock and reset
	input wire logic                        clk_i,
	input wire logic                        rst_i,
	// bus
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_we_i,
	input wire logic [31:0]                 wb_dat_o,
	input wire logic                        wb_ack_o,
	// pins and interrupt
	input wire serial_out_t [NUM_PORTS-1:0] pins_o,
	input wire logic                        irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	serial_out_t p0;
	assign p0 = pins_o[0];

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	property p_ack_answer;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer)
		else $error("request not acked");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	// read data only moves together with an ack
	property p_dat_hold;
		!wb_ack_o && !$past(rst_i) |-> $stable(wb_dat_o);
	endproperty
	a_dat_hold: assert property (p_dat_hold)
		else $error("read data moved without ack");
	property p_reset_out;
		$fell(rst_i) |-> !wb_ack_o && !irq_o && p0.ssel_n && !p0.drive_en;
	endproperty
	a_reset_out: assert property (p_reset_out)
		else $error("outputs not at reset level");
	// back-to-back frames are legal, so check the shortest frame the bench sends instead:
	// four bits of two half bits, each half at least one cycle
	property p_frame_len;
		$fell(p0.ssel_n) |-> (!p0.ssel_n) [*8];
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("frame shorter than four bits");
	property p_mosi_edge;
		!p0.ssel_n && $past(!p0.ssel_n) && $changed(p0.mosi) |-> $changed(p0.sck);
	endproperty
	a_mosi_edge: assert property (p_mosi_edge)
		else $error("data moved off a clock edge");
	property p_start_en;
		$fell(p0.ssel_n) |-> $past(p0.drive_en);
	endproperty
	a_start_en: assert property (p_start_en)
		else $error("frame while not master");
	property p_en_write;
		$rose(p0.drive_en) |-> $past(wb_ack_o && wb_we_i);
	endproperty
	a_en_write: assert property (p_en_write)
		else $error("drive enable rose without write");
	// idle clock stays put unless a register write lands
	property p_sck_idle;
		p0.ssel_n && $past(p0.ssel_n) && !$past(wb_ack_o) && !$past(rst_i) |-> $stable(p0.sck);
	endproperty
	a_sck_idle: assert property (p_sck_idle)
		else $error("clock moved between frames");
endmodule : sync_serial_port_regs_checker

bind sync_serial_port_regs sync_serial_port_regs_checker sync_serial_port_regs_checker_i (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pins_o(pins_o), .irq_o(irq_o));

// ### sync_serial_port_regs_tb.sv
// self-checking bench for the two-port serial register block
// assumes package constants, one 40 MHz clock and echo slaves on both ports
module sync_serial_port_regs_tb
	import serial_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                        clk_i = 1'b0;
	logic                        rst_i = 1'b1;
	logic                        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
	logic [31:0]                 adr = 32'h0, wdat = 32'h0, rdat, q, d, w;
	logic [3:0]                  sel = 4'h0;
	logic [NUM_PORTS-1:0]        miso;
	serial_out_t [NUM_PORTS-1:0] pins;
	int                          error_cnt = 0, checked = 0, low = 0, pp = 0, r, t, ps, bits;
	logic [31:0] ofs [8] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h10, 32'h14, 32'h18, 32'h1C};
	logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'h3, 32'h0, 32'h0, 32'h8, 32'h0};
	logic [31:0] msk [8] = '{32'hFFFF, 32'h7, 32'h0, 32'h0, 32'hFF, 32'hF, 32'h0, 32'h0};
	logic [3:0]  sz [4] = '{4'h3, 4'h7, 4'hF, 4'hA};

	sync_serial_port_regs sync_serial_port_regs_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .miso_i(miso), .pins_o(pins), .irq_o(irq));
	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_slave
		echo_slave echo_slave_i (.clk_i(clk_i), .pins_i(pins[g]), .miso_o(miso[g]));
	end

	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;
	// frame length of the port under test
	always @(posedge clk_i) begin
		if (pins[pp].ssel_n === 1'b0) begin
			low <= low + 1;
		end
	end

	task automatic wrap_up;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up
	task automatic check(input string nm, input logic [31:0] seen, e);
		checked++;
		if (seen !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, seen);
		end
	endtask : check
	// one classic cycle; waits for ack, then releases for a cycle
	task automatic wb(input logic wr_en, input logic [31:0] a, dat);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr_en;
		adr <= a;
		wdat <= dat;
		sel <= 4'hF;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			error_cnt++;
			wrap_up();
		end
		@(posedge clk_i);
	endtask : wb
	task automatic rd(input logic [31:0] a, e, input string nm);
		wb(1'b0, a, 32'h0);
		check(nm, q, e);
	endtask : rd
	function automatic logic [31:0] base(input int p);
		return p ? PORT_BASE_1 : PORT_BASE_0;
	endfunction : base

	initial begin
		void'($urandom(32'h5C5F));
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		// reset values, read-only places and an unmapped address on both ports
		for (int p = 0; p < NUM_PORTS; p++) begin
			for (int k = 0; k < 8; k++) begin
				rd(base(p) + ofs[k], rv[k], "reset value");
				if (msk[k] == 32'h0 && k != 2) begin
					wb(1'b1, base(p) + ofs[k], 32'hFFFF_FFFF);
					rd(base(p) + ofs[k], rv[k], "read only");
				end
			end
			wb(1'b1, base(p) + 32'h100, 32'hFFFF_FFFF);
			rd(base(p) + 32'h100, 32'h0, "unmapped");
		end
		// random read-back of every read-write register, format codes 0 to 2
		for (int i = 0; i < 6; i++) begin
			for (int k = 0; k < 8; k++) begin
				d = $urandom;
				d[5:4] = 2'(i % 3);
				if (k == 0 && d[3:0] < 4'h3) begin
					d[3:0] = 4'h3;
				end
				if (msk[k] != 32'h0) begin
					wb(1'b1, base(i % 2) + ofs[k], d);
					rd(base(i % 2) + ofs[k], d & msk[k], "read back");
				end
			end
			wb(1'b1, base(i % 2) + 32'h14, 32'h0);
		end
		// frames: sizes, clock idle levels and edges, rates, interrupts
		// the last two frames use the other formats, which ignore idle and edge bits
		for (int i = 0; i < 6; i++) begin
			pp = i % 2;
			r = $urandom % 3;
			ps = 2 * ($urandom % 2 + 1);
			bits = sz[i % 4] + 1;
			w = $urandom;
			wb(1'b1, base(pp), {16'h0, 8'(r), i[1], i[0], 2'(i / 4 * (i - 3)), sz[i % 4]});
			wb(1'b1, base(pp) + 32'h10, 32'(ps));
			wb(1'b1, base(pp) + 32'h4, 32'h2);
			wb(1'b1, base(pp) + 32'h20, 32'h3);
			check("idle clock", 32'(pins[pp].sck), 32'(i[0] & (i < 4)));
			check("drive enable", 32'(pins[pp].drive_en), 32'h1);
			low = 0;
			wb(1'b1, base(pp) + 32'h8, w);
			t = 0;
			do begin
				wb(1'b0, base(pp) + 32'h18, 32'h0);
				t++;
			end while (q[1] !== 1'b1 && t < 300);
			check("frame done", 32'(q[1]), 32'h1);
			if (q[1] !== 1'b1) begin
				wrap_up();
			end
			rd(base(pp) + 32'h8, w & ((32'h1 << bits) - 1), "rx word");
			check("frame cycles", low, bits * 2 * ((ps * (r + 1)) / 2));
			rd(base(pp) + 32'h18, 32'hA, "raw");
			wb(1'b1, base(pp) + 32'h14, 32'h2);
			check("irq set", 32'(irq), 32'h1);
			rd(base(pp) + 32'h1C, 32'h2, "masked");
			wb(1'b1, base(pp) + 32'h20, 32'h2);
			check("irq clear", 32'(irq), 32'h0);
			rd(base(pp) + 32'h18, 32'h8, "raw cleared");
			rd(base(pp) + 32'h8, 32'h0, "rx empty");
			wb(1'b1, base(pp) + 32'h14, 32'h0);
		end
		// a slow frame keeps five words queued; a mid-run reset must empty them
		wb(1'b1, base(0), 32'h0000_FF0F);
		wb(1'b1, base(0) + 32'h10, 32'h4);
		wb(1'b1, base(0) + 32'h4, 32'h2);
		for (int k = 0; k < 6; k++) begin
			wb(1'b1, base(0) + 32'h8, $urandom);
		end
		rd(base(0) + 32'h18, 32'h0, "tx above half");
		rd(base(0) + 32'hC, 32'h12, "busy status");
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check("pins after reset", 32'(pins[0]), 32'h2);
		rd(base(0) + 32'hC, 32'h3, "status after reset");
		rd(base(0) + 32'h18, 32'h8, "raw after reset");
		wrap_up();
	end
endmodule : sync_serial_port_regs_tb
